/* File: src/udcs_defs.svh */
`ifndef UDCS_DEFS_SVH
`define UDCS_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define UDCS_OFF_EVENT     3'h0
`define UDCS_OFF_ENABLE    3'h1
`define UDCS_OFF_CONTROL   3'h2
`define UDCS_OFF_NODE      3'h3
`define UDCS_OFF_XFER_INFO 3'h4
`define UDCS_OFF_EP0       3'h5

// ---------------------------------------------------------------
// Event flag and mask bit positions
// ---------------------------------------------------------------
`define UDCS_EV_DONE       7
`define UDCS_EV_OVERWRITE  5
`define UDCS_EV_FAULT      4
`define UDCS_EV_IDLE       3
`define UDCS_EV_WAKE       2
`define UDCS_EV_BUSRST     1
`define UDCS_EV_SOF        0
`define UDCS_EV_SW_MASK    8'h3f

// ---------------------------------------------------------------
// Link control bit positions
// ---------------------------------------------------------------
`define UDCS_CTL_WAKE_SEEN 7
`define UDCS_CTL_RST_SEEN  6
`define UDCS_CTL_RESUME    3
`define UDCS_CTL_REG_OFF   2
`define UDCS_CTL_FSLEEP    1
`define UDCS_CTL_FRESET    0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define UDCS_RST_EVENT     8'h00
`define UDCS_RST_ENABLE    8'h00
`define UDCS_RST_CONTROL   8'h06
`define UDCS_RST_NODE      7'h00
`define UDCS_RST_XFER_INFO 8'h00
`define UDCS_RST_EP0       8'h00

// ---------------------------------------------------------------
// Token kinds, handshake states, fault codes
// ---------------------------------------------------------------
`define UDCS_PID_OUT       2'h0
`define UDCS_PID_IN        2'h2
`define UDCS_PID_SETUP     2'h3
`define UDCS_HS_DISABLED   2'h0
`define UDCS_HS_STALL      2'h1
`define UDCS_HS_NAK        2'h2
`define UDCS_HS_VALID      2'h3
`define UDCS_FAULT_NONE    3'h0
`define UDCS_FAULT_STUFF   3'h1
`define UDCS_FAULT_CRC     3'h2
`define UDCS_FAULT_EOP     3'h3
`define UDCS_FAULT_PID     3'h4
`define UDCS_FAULT_MEM     3'h5
`define UDCS_FAULT_OTHER   3'h7

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define UDCS_MCLK_MHZ      125
`define UDCS_IDLE_TIME_US  3000

`endif

/* File: src/udcs_pkg.sv */
package udcs_pkg;

	// Answer the device gives to an addressed transaction
	typedef enum logic [1:0] {
		HS_NONE,
		HS_ACK,
		HS_NAK,
		HS_STALL
	} udcs_hs_t;

	// Orders the host end accepts from its user
	typedef enum logic [2:0] {
		CMD_RESET,
		CMD_RESUME,
		CMD_QUIET,
		CMD_SOF,
		CMD_XFER,
		CMD_FAULT
	} udcs_cmd_t;

	typedef enum logic [1:0] {
		H_IDLE,
		H_RESET,
		H_RESUME,
		H_QUIET
	} udcs_hstate_t;

endpackage

/* File: src/udcs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface udcs_link_if;
	logic                  bus_reset;
	logic                  bus_resume;
	logic                  bus_active;
	logic                  sof;
	logic                  xfer_valid;
	logic [1:0]            xfer_pid;
	logic [1:0]            xfer_ep;
	logic [6:0]            xfer_addr;
	logic                  xfer_dir;
	logic                  fault_valid;
	logic [2:0]            fault_code;
	logic                  dev_resume;
	logic                  dev_power;
	udcs_pkg::udcs_hs_t    dev_hs;

	modport dev (
		input  bus_reset, bus_resume, bus_active, sof, xfer_valid, xfer_pid, xfer_ep,
		       xfer_addr, xfer_dir, fault_valid, fault_code,
		output dev_resume, dev_power, dev_hs
	);
	modport host (
		output bus_reset, bus_resume, bus_active, sof, xfer_valid, xfer_pid, xfer_ep,
		       xfer_addr, xfer_dir, fault_valid, fault_code,
		input  dev_resume, dev_power, dev_hs
	);
endinterface

`default_nettype wire

/* File: src/udcs_device.sv */
// How it works
// (R1) SETUP overwrite leaves transfer info untouched
// (R2) Any link error sets fault flag
// (R3) Idle over 3 ms sets idle flag
// (R4) Idle detect armed by reset, off during forced sleep
// (R5) Activity in suspend sets wake flag, own interrupt
// (R6) Bus reset and SOF set their flags
// (R7) Bus reset clears address and endpoint control
// (R8) Write zero clears flag, one keeps
// (R9) Interrupt when flag and mask set, not disabled
// (R10) Resume and reset starts set seen bits
// (R11) Resume bit drives wake signalling
// (R12) Regulator-off bit switches regulator off
// (R13) Software waits 3 us after regulator on
// (R14) Force-sleep suspends, cleared by bus activity
// (R15) Force-reset holds reset, release raises reset event
// (R16) Seven-bit address, bit 7 reads zero
// (R17) Token kind holds upper PID bits
// (R18) Endpoint 1/2 direction recorded on correct transfer
// (R19) Endpoint number field names endpoint
// (R20) Fault code encodes error type
// (R21) Fault code loaded on error, cleared with flag
// (R22) Reset clears endpoint bits; done set per transfer
// (R23) Handshake state: disabled, stall, NAK, valid
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "udcs_defs.svh"

module udcs_device #(
	parameter int IDLE_CYCLES = `UDCS_IDLE_TIME_US * `UDCS_MCLK_MHZ,
	parameter int IDLE_W      = 20
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	udcs_link_if.dev        link,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       global_irq_dis,
	output logic            irq,
	output logic            wake_irq
);

	logic [7:0]        flags, next_flags;
	logic [7:0]        mask, next_mask;
	logic [7:0]        ctl, next_ctl;
	logic [6:0]        node, next_node;
	logic [7:0]        info, next_info;
	logic [7:0]        ep0, next_ep0;
	logic [IDLE_W-1:0] idle_cnt, next_idle_cnt;
	logic              armed, next_armed;
	logic              suspended, next_suspended;
	logic              rst_q, next_rst_q;
	logic              resume_q, next_resume_q;
	logic [7:0]        next_rdata;
	logic [7:0]        flags_view;
	logic              wr_ev, wr_ctl, wr_ep0;
	logic              iface_rst, activity, force_iface_reset_bit_release;
	logic              hit0, ok0, is_setup;
	logic [1:0]        stat0;

	// ---------------------------------------------------------------
	// Link decode
	// ---------------------------------------------------------------
	assign wr_ev     = reg_wr && reg_addr == `UDCS_OFF_EVENT;
	assign wr_ctl    = reg_wr && reg_addr == `UDCS_OFF_CONTROL;
	assign wr_ep0    = reg_wr && reg_addr == `UDCS_OFF_EP0;
	assign iface_rst = link.bus_reset || ctl[`UDCS_CTL_FRESET];
	assign activity  = link.bus_active || link.bus_resume || link.bus_reset;
	assign force_iface_reset_bit_release = wr_ctl && ctl[`UDCS_CTL_FRESET] && !reg_wdata[`UDCS_CTL_FRESET];
	assign is_setup  = link.xfer_pid == `UDCS_PID_SETUP;
	assign hit0      = link.xfer_valid && link.xfer_ep == 2'h0 && link.xfer_addr == node
		&& !iface_rst;
	assign stat0     = link.xfer_pid == `UDCS_PID_IN ? ep0[5:4] : ep0[1:0];
	// (R23) Valid handles, setup needs enabled
	assign ok0       = is_setup ? ep0[1:0] != `UDCS_HS_DISABLED : stat0 == `UDCS_HS_VALID;
	assign flags_view = {ep0[7], 1'b0, flags[5:0]};

	// ---------------------------------------------------------------
	// Link outputs
	// ---------------------------------------------------------------
	// (R11) Resume bit drives signalling
	assign link.dev_resume = ctl[`UDCS_CTL_RESUME];
	// (R12) Regulator follows off bit
	assign link.dev_power  = !ctl[`UDCS_CTL_REG_OFF];

	always_comb begin
		link.dev_hs = udcs_pkg::HS_NONE;
		if (hit0) begin
			if (is_setup && ok0)
				link.dev_hs = udcs_pkg::HS_ACK;
			else
				case (stat0)
					`UDCS_HS_STALL: link.dev_hs = udcs_pkg::HS_STALL;
					`UDCS_HS_NAK:   link.dev_hs = udcs_pkg::HS_NAK;
					`UDCS_HS_VALID: link.dev_hs = udcs_pkg::HS_ACK;
					default:        link.dev_hs = udcs_pkg::HS_NONE;
				endcase
		end else if (link.xfer_valid && link.xfer_ep != 2'h0 && link.xfer_addr == node
				&& !iface_rst)
			link.dev_hs = udcs_pkg::HS_ACK;
	end

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	// (R9) Flag and mask, gated by disable
	assign irq      = |(flags_view & mask & ~(8'h01 << `UDCS_EV_WAKE)) && !global_irq_dis;
	// (R5) Wake event has its own line
	assign wake_irq = flags[`UDCS_EV_WAKE] && mask[`UDCS_EV_WAKE] && !global_irq_dis;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_flags     = flags;
		next_mask      = mask;
		next_ctl       = ctl;
		next_node      = node;
		next_info      = info;
		next_ep0       = ep0;
		next_idle_cnt  = idle_cnt;
		next_armed     = armed;
		next_suspended = suspended;
		next_rst_q     = link.bus_reset;
		next_resume_q  = link.bus_resume || ctl[`UDCS_CTL_RESUME];
		next_rdata     = 8'h00;

		// Software writes
		// (R8) Zero clears, one keeps
		if (wr_ev)
			next_flags = flags & (reg_wdata | ~`UDCS_EV_SW_MASK);
		// (R21) Fault code cleared with flag
		if (wr_ev && flags[`UDCS_EV_FAULT] && !reg_wdata[`UDCS_EV_FAULT])
			next_info[2:0] = `UDCS_FAULT_NONE;
		if (reg_wr && reg_addr == `UDCS_OFF_ENABLE)
			next_mask = reg_wdata;
		if (wr_ctl)
			next_ctl[3:0] = reg_wdata[3:0];
		// (R16) Seven-bit address
		if (reg_wr && reg_addr == `UDCS_OFF_NODE)
			next_node = reg_wdata[6:0];
		if (wr_ep0) begin
			next_ep0 = {ep0[7] & reg_wdata[7], reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
		end

		// (R10) Seen bits on sequence start
		if (link.bus_resume && !resume_q)
			next_ctl[`UDCS_CTL_WAKE_SEEN] = 1'b1;
		if (link.bus_reset && !rst_q)
			next_ctl[`UDCS_CTL_RST_SEEN] = 1'b1;

		// (R14) Forced sleep enters suspend
		if (next_ctl[`UDCS_CTL_FSLEEP] && !ctl[`UDCS_CTL_FSLEEP]) begin
			next_suspended = 1'b1;
			// (R4) Idle detect off while forced
			next_armed     = 1'b0;
		end

		// (R3) Idle detection over the window
		if (activity || !armed || suspended) begin
			next_idle_cnt = '0;
		end else if (idle_cnt >= IDLE_W'(IDLE_CYCLES)) begin
			next_flags[`UDCS_EV_IDLE] = 1'b1;
			next_suspended            = 1'b1;
			next_idle_cnt             = '0;
		end else begin
			next_idle_cnt = idle_cnt + 1'b1;
		end

		if (suspended && activity) begin
			// (R5) Wake flag on activity
			next_flags[`UDCS_EV_WAKE]   = 1'b1;
			next_suspended              = 1'b0;
			// (R14) Hardware clears force sleep
			next_ctl[`UDCS_CTL_FSLEEP]  = 1'b0;
		end

		// (R4) Rearmed after resume ends
		if (resume_q && !(link.bus_resume || ctl[`UDCS_CTL_RESUME])
				&& !ctl[`UDCS_CTL_FSLEEP])
			next_armed = 1'b1;

		// (R6) Start of frame
		if (link.sof)
			next_flags[`UDCS_EV_SOF] = 1'b1;

		// (R2) Link error raises fault
		if (link.fault_valid) begin
			next_flags[`UDCS_EV_FAULT] = 1'b1;
			// (R20) Fault code loaded
			next_info[2:0]             = link.fault_code;
		end

		// Control endpoint transaction
		if (hit0) begin
			if (is_setup && ok0 && ep0[7]) begin
				// (R1) Overwrite leaves info alone
				next_flags[`UDCS_EV_OVERWRITE] = 1'b1;
				next_ep0[6:4]             = {1'b1, `UDCS_HS_NAK};
				next_ep0[2:0]             = {1'b0, `UDCS_HS_NAK};
			end else if (ok0) begin
				// (R22) Done flag per transfer
				next_ep0[7]    = 1'b1;
				// (R17) Token kind recorded
				next_info[7:6] = link.xfer_pid;
				// (R19) Endpoint zero
				next_info[4:3] = 2'h0;
				next_ep0[5:4]  = `UDCS_HS_NAK;
				next_ep0[1:0]  = `UDCS_HS_NAK;
				if (is_setup) begin
					next_ep0[6] = 1'b1;
					next_ep0[2] = 1'b0;
				end else if (link.xfer_pid == `UDCS_PID_IN)
					next_ep0[6] = !ep0[6];
				else
					next_ep0[2] = !ep0[2];
			end else if (stat0 == `UDCS_HS_STALL) begin
				next_ep0[5:4] = `UDCS_HS_STALL;
				next_ep0[1:0] = `UDCS_HS_STALL;
			end
		end else if (link.dev_hs == udcs_pkg::HS_ACK) begin
			// (R18) Direction of endpoint 1/2
			next_info[5]   = link.xfer_dir;
			// (R19) Endpoint number recorded
			next_info[4:3] = link.xfer_ep;
		end

		// (R6) Bus reset flag
		if (link.bus_reset && !rst_q) begin
			next_flags[`UDCS_EV_BUSRST] = 1'b1;
			next_armed                  = 1'b1;
		end
		// (R15) Release of forced reset
		if (force_iface_reset_bit_release) begin
			next_flags[`UDCS_EV_BUSRST] = 1'b1;
			next_armed                  = 1'b1;
		end
		// (R7) Reset clears address and endpoint
		if (iface_rst) begin
			next_node     = `UDCS_RST_NODE;
			// (R22) Bits 6:4 and 2:0 cleared
			next_ep0[6:4] = 3'h0;
			next_ep0[2:0] = 3'h0;
			next_idle_cnt = '0;
		end

		// Read mux
		if (reg_rd)
			case (reg_addr)
				`UDCS_OFF_EVENT:     next_rdata = flags_view;
				`UDCS_OFF_ENABLE:    next_rdata = {mask[7], 1'b0, mask[5:0]};
				`UDCS_OFF_CONTROL:   next_rdata = {ctl[7:6], 2'h0, ctl[3:0]};
				`UDCS_OFF_NODE:      next_rdata = {1'b0, node};
				`UDCS_OFF_XFER_INFO: next_rdata = info;
				`UDCS_OFF_EP0:       next_rdata = ep0;
				default:             next_rdata = 8'h00;
			endcase
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flags     <= `UDCS_RST_EVENT;
			mask      <= `UDCS_RST_ENABLE;
			ctl       <= `UDCS_RST_CONTROL;
			node      <= `UDCS_RST_NODE;
			info      <= `UDCS_RST_XFER_INFO;
			ep0       <= `UDCS_RST_EP0;
			idle_cnt  <= '0;
			armed     <= 1'b1;
			// Control resets with force sleep set
			suspended <= 1'b1;
			rst_q     <= 1'b0;
			resume_q  <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			flags     <= next_flags;
			mask      <= next_mask;
			ctl       <= next_ctl;
			node      <= next_node;
			info      <= next_info;
			ep0       <= next_ep0;
			idle_cnt  <= next_idle_cnt;
			armed     <= next_armed;
			suspended <= next_suspended;
			rst_q     <= next_rst_q;
			resume_q  <= next_resume_q;
			reg_rdata <= next_rdata;
		end
	end

endmodule // udcs_device

`default_nettype wire

/* File: src/udcs_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "udcs_defs.svh"

module udcs_host #(
	parameter int CW = 20
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	udcs_link_if.host                link,
	input  wire logic                cmd_valid,
	input  wire udcs_pkg::udcs_cmd_t cmd_kind,
	input  wire logic [CW-1:0]       cmd_len,
	input  wire logic [1:0]          cmd_pid,
	input  wire logic [1:0]          cmd_ep,
	input  wire logic [6:0]          cmd_addr,
	input  wire logic                cmd_dir,
	input  wire logic [2:0]          cmd_fault,
	output logic                     cmd_ready,
	output udcs_pkg::udcs_hs_t       hs_seen,
	output logic                     remote_wake,
	output logic                     dev_powered
);

	udcs_pkg::udcs_hstate_t state, next_state;
	logic [CW-1:0]          cnt, next_cnt;
	logic                   sof_q, next_sof;
	logic                   xv_q, next_xv;
	logic [1:0]             pid_q, next_pid;
	logic [1:0]             ep_q, next_ep;
	logic [6:0]             addr_q, next_addr;
	logic                   dir_q, next_dir;
	logic                   fv_q, next_fv;
	logic [2:0]             fc_q, next_fc;
	udcs_pkg::udcs_hs_t     next_hs;

	// ---------------------------------------------------------------
	// Link drive
	// ---------------------------------------------------------------
	assign cmd_ready        = state == udcs_pkg::H_IDLE;
	assign link.bus_reset   = state == udcs_pkg::H_RESET;
	assign link.bus_resume  = state == udcs_pkg::H_RESUME;
	assign link.bus_active  = state == udcs_pkg::H_IDLE;
	assign link.sof         = sof_q;
	assign link.xfer_valid  = xv_q;
	assign link.xfer_pid    = pid_q;
	assign link.xfer_ep     = ep_q;
	assign link.xfer_addr   = addr_q;
	assign link.xfer_dir    = dir_q;
	assign link.fault_valid = fv_q;
	assign link.fault_code  = fc_q;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_sof   = 1'b0;
		next_xv    = 1'b0;
		next_pid   = pid_q;
		next_ep    = ep_q;
		next_addr  = addr_q;
		next_dir   = dir_q;
		next_fv    = 1'b0;
		next_fc    = fc_q;
		next_hs    = xv_q ? link.dev_hs : hs_seen;
		case (state)
			udcs_pkg::H_IDLE: begin
				if (cmd_valid) begin
					next_cnt = cmd_len;
					case (cmd_kind)
						udcs_pkg::CMD_RESET:  next_state = udcs_pkg::H_RESET;
						udcs_pkg::CMD_RESUME: next_state = udcs_pkg::H_RESUME;
						udcs_pkg::CMD_QUIET:  next_state = udcs_pkg::H_QUIET;
						udcs_pkg::CMD_SOF:    next_sof = 1'b1;
						udcs_pkg::CMD_XFER: begin
							next_xv   = 1'b1;
							next_pid  = cmd_pid;
							next_ep   = cmd_ep;
							next_addr = cmd_addr;
							next_dir  = cmd_dir;
						end
						udcs_pkg::CMD_FAULT: begin
							next_fv = 1'b1;
							next_fc = cmd_fault;
						end
						default: next_state = udcs_pkg::H_IDLE;
					endcase
				end
			end
			udcs_pkg::H_RESET,
			udcs_pkg::H_RESUME,
			udcs_pkg::H_QUIET: begin
				if (cnt == '0)
					next_state = udcs_pkg::H_IDLE;
				else
					next_cnt = cnt - 1'b1;
			end
			default: next_state = udcs_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state       <= udcs_pkg::H_IDLE;
			cnt         <= '0;
			sof_q       <= 1'b0;
			xv_q        <= 1'b0;
			pid_q       <= 2'h0;
			ep_q        <= 2'h0;
			addr_q      <= 7'h00;
			dir_q       <= 1'b0;
			fv_q        <= 1'b0;
			fc_q        <= 3'h0;
			hs_seen     <= udcs_pkg::HS_NONE;
			remote_wake <= 1'b0;
			dev_powered <= 1'b0;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			sof_q       <= next_sof;
			xv_q        <= next_xv;
			pid_q       <= next_pid;
			ep_q        <= next_ep;
			addr_q      <= next_addr;
			dir_q       <= next_dir;
			fv_q        <= next_fv;
			fc_q        <= next_fc;
			hs_seen     <= next_hs;
			remote_wake <= link.dev_resume;
			dev_powered <= link.dev_power;
		end
	end

endmodule // udcs_host

`default_nettype wire

/* File: tb/udcs_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module udcs_sva (
	input wire logic               mclk,
	input wire logic               rst,
	input wire logic               bus_reset,
	input wire logic               bus_resume,
	input wire logic               bus_active,
	input wire logic               sof,
	input wire logic               xfer_valid,
	input wire logic [1:0]         xfer_ep,
	input wire logic               fault_valid,
	input wire logic [2:0]         fault_code,
	input wire logic               dev_resume,
	input wire logic               dev_power,
	input wire udcs_pkg::udcs_hs_t dev_hs
);
	// ---------------------------------------------------------------
	// Link checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_hs_needs_xfer: assert property (dev_hs != udcs_pkg::HS_NONE |-> xfer_valid)
		else $error("answer without transaction");
	a_hs_reset_quiet: assert property ($rose(bus_reset) |-> (dev_hs == udcs_pkg::HS_NONE)[*2])
		else $error("answer during bus reset");
	a_reset_exclusive: assert property (bus_reset |-> !xfer_valid && !sof && !bus_resume)
		else $error("traffic during bus reset");
	a_quiet_silent: assert property (!bus_active |-> !xfer_valid && !sof)
		else $error("traffic while bus idle");
	a_one_pulse: assert property (sof |-> !xfer_valid && !fault_valid)
		else $error("two link pulses at once");
	a_fault_known: assert property (fault_valid |-> fault_code != 3'h0 && fault_code != 3'h6)
		else $error("fault pulse with unused code");
	a_ep_legal: assert property (xfer_valid |-> xfer_ep != 2'h3)
		else $error("transaction to unknown endpoint");
	a_resume_kept: assert property (bus_reset |=> $stable(dev_resume))
		else $error("bus reset changed resume drive");
	a_power_kept: assert property (bus_reset |=> $stable(dev_power))
		else $error("bus reset changed regulator");
endmodule // udcs_sva

`default_nettype wire

/* File: tb/tb_usb_device_control_status.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_usb_device_control_status;
	logic                mclk, rst, reg_wr, reg_rd, global_irq_dis, irq, wake_irq;
	logic                cmd_valid, cmd_dir, cmd_ready, remote_wake, dev_powered;
	logic [2:0]          reg_addr, cmd_fault;
	logic [7:0]          reg_wdata, reg_rdata;
	logic [19:0]         cmd_len;
	logic [1:0]          cmd_pid, cmd_ep;
	logic [6:0]          cmd_addr;
	udcs_pkg::udcs_cmd_t cmd_kind;
	udcs_pkg::udcs_hs_t  hs_seen;
	int                  err_count, checked;

	udcs_link_if lnk ();
	udcs_device #(.IDLE_CYCLES(20)) i_udcs_device (.mclk(mclk), .rst(rst), .link(lnk.dev),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .global_irq_dis(global_irq_dis), .irq(irq), .wake_irq(wake_irq));
	udcs_host i_udcs_host (.mclk(mclk), .rst(rst), .link(lnk.host), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_len(cmd_len), .cmd_pid(cmd_pid), .cmd_ep(cmd_ep),
		.cmd_addr(cmd_addr), .cmd_dir(cmd_dir), .cmd_fault(cmd_fault), .cmd_ready(cmd_ready),
		.hs_seen(hs_seen), .remote_wake(remote_wake), .dev_powered(dev_powered));
	udcs_sva u_sva (.mclk(mclk), .rst(rst), .bus_reset(lnk.bus_reset),
		.bus_resume(lnk.bus_resume), .bus_active(lnk.bus_active), .sof(lnk.sof),
		.xfer_valid(lnk.xfer_valid), .xfer_ep(lnk.xfer_ep), .fault_valid(lnk.fault_valid),
		.fault_code(lnk.fault_code), .dev_resume(lnk.dev_resume), .dev_power(lnk.dev_power),
		.dev_hs(lnk.dev_hs));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task wrap_up;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check8(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task check1(input string n, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %b got %b", n, e, g);
		end
	endtask
	task check_hs(input string n, input udcs_pkg::udcs_hs_t e, input udcs_pkg::udcs_hs_t g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %0d got %0d", n, e, g);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	task rd_chk(input string n, input logic [2:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(negedge mclk);
		check8(n, e, reg_rdata);
	endtask
	task wait_ready;
		int i;
		@(negedge mclk);
		for (i = 0; i < 500 && cmd_ready !== 1'h1; i++) @(negedge mclk);
		if (i >= 500) begin
			err_count++;
			$display("wrong value cmd_ready exp 1 got %b", cmd_ready);
			wrap_up();
		end else begin
			repeat (3) @(negedge mclk);
		end
	endtask
	task cmd(input udcs_pkg::udcs_cmd_t k, input logic [19:0] n, input logic [1:0] p, e,
		input logic [6:0] a, input logic d, input logic [2:0] f);
		wait_ready();
		@(posedge mclk);
		cmd_valid <= 1'h1;
		cmd_kind <= k;
		cmd_len <= n;
		cmd_pid <= p;
		cmd_ep <= e;
		cmd_addr <= a;
		cmd_dir <= d;
		cmd_fault <= f;
		@(posedge mclk);
		cmd_valid <= 1'h0;
		wait_ready();
	endtask
	task xfer(input logic [1:0] p, e, input logic [6:0] a, input logic d);
		cmd(udcs_pkg::CMD_XFER, 20'h0, p, e, a, d, 3'h0);
	endtask
	task lvl(input udcs_pkg::udcs_cmd_t k, input logic [19:0] n);
		cmd(k, n, 2'h0, 2'h0, 7'h0, 1'h0, 3'h0);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_reset_wake;
		rd_chk("ctl", 3'h2, 8'h04);
		rd_chk("evt", 3'h0, 8'h04);
		check1("power", 1'h0, lnk.dev_power);
		rd_chk("node", 3'h3, 8'h00);
		rd_chk("info", 3'h4, 8'h00);
		rd_chk("ep0", 3'h5, 8'h00);
		rd_chk("gap", 3'h7, 8'h00);
		wr(3'h1, 8'h04);
		@(negedge mclk);
		check1("wake_irq", 1'h1, wake_irq);
		check1("irq", 1'h0, irq);
		@(posedge mclk);
		global_irq_dis <= 1'h1;
		@(negedge mclk);
		check1("wake_irq", 1'h0, wake_irq);
		@(posedge mclk);
		global_irq_dis <= 1'h0;
		wr(3'h0, 8'hfb);
		@(negedge mclk);
		check1("wake_irq", 1'h0, wake_irq);
		rd_chk("evt", 3'h0, 8'h00);
	endtask
	task t_regs;
		wr(3'h1, 8'hff);
		rd_chk("mask", 3'h1, 8'hbf);
		wr(3'h3, 8'hff);
		rd_chk("node", 3'h3, 8'h7f);
		wr(3'h4, 8'hff);
		rd_chk("info", 3'h4, 8'h00);
		wr(3'h6, 8'h5a);
		rd_chk("gap", 3'h6, 8'h00);
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h00);
		@(negedge mclk);
		check1("power", 1'h1, lnk.dev_power);
		repeat (375) @(posedge mclk);
		@(negedge mclk);
		check1("dev_powered", 1'h1, dev_powered);
		wr(3'h2, 8'h08);
		@(negedge mclk);
		check1("resume", 1'h1, lnk.dev_resume);
		@(negedge mclk);
		check1("remote_wake", 1'h1, remote_wake);
		wr(3'h2, 8'hf0);
		rd_chk("ctl", 3'h2, 8'h00);
	endtask
	task t_bus_reset;
		wr(3'h0, 8'h00);
		wr(3'h3, 8'h05);
		wr(3'h5, 8'h33);
		wr(3'h1, 8'h02);
		lvl(udcs_pkg::CMD_RESET, 20'h4);
		rd_chk("evt", 3'h0, 8'h02);
		check1("irq", 1'h1, irq);
		rd_chk("ctl", 3'h2, 8'h40);
		rd_chk("node", 3'h3, 8'h00);
		rd_chk("ep0", 3'h5, 8'h00);
		wr(3'h0, 8'hfd);
		@(negedge mclk);
		check1("irq", 1'h0, irq);
		wr(3'h1, 8'h00);
	endtask
	task t_setup;
		wr(3'h5, 8'h33);
		xfer(2'h3, 2'h0, 7'h00, 1'h0);
		check_hs("hs", udcs_pkg::HS_ACK, hs_seen);
		rd_chk("ep0", 3'h5, 8'he2);
		rd_chk("info", 3'h4, 8'hc0);
		xfer(2'h2, 2'h2, 7'h00, 1'h1);
		check_hs("hs", udcs_pkg::HS_ACK, hs_seen);
		rd_chk("info", 3'h4, 8'hf0);
		xfer(2'h0, 2'h1, 7'h09, 1'h0);
		check_hs("hs", udcs_pkg::HS_NONE, hs_seen);
		xfer(2'h3, 2'h0, 7'h00, 1'h0);
		rd_chk("info", 3'h4, 8'hf0);
		rd_chk("evt", 3'h0, 8'ha0);
		xfer(2'h2, 2'h0, 7'h00, 1'h0);
		check_hs("hs", udcs_pkg::HS_NAK, hs_seen);
		wr(3'h5, 8'h91);
		xfer(2'h0, 2'h0, 7'h00, 1'h0);
		check_hs("hs", udcs_pkg::HS_STALL, hs_seen);
		rd_chk("ep0", 3'h5, 8'h91);
		wr(3'h5, 8'h00);
		wr(3'h0, 8'h00);
		rd_chk("evt", 3'h0, 8'h00);
	endtask
	task t_fault;
		int i;
		for (i = 1; i < 8; i++) if (i != 6) begin
			cmd(udcs_pkg::CMD_FAULT, 20'h0, 2'h0, 2'h0, 7'h0, 1'h0, i[2:0]);
			rd_chk("evt", 3'h0, 8'h10);
			rd_chk("info", 3'h4, {5'h1e, i[2:0]});
			wr(3'h0, 8'hef);
			rd_chk("info", 3'h4, 8'hf0);
		end
	endtask
	task t_idle;
		lvl(udcs_pkg::CMD_QUIET, 20'h1e);
		rd_chk("evt", 3'h0, 8'h0c);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h02);
		rd_chk("ctl", 3'h2, 8'h40);
		rd_chk("evt", 3'h0, 8'h04);
	endtask
	task t_force_reset;
		wr(3'h0, 8'h00);
		wr(3'h3, 8'h05);
		wr(3'h2, 8'h01);
		wr(3'h2, 8'h00);
		rd_chk("evt", 3'h0, 8'h02);
		rd_chk("node", 3'h3, 8'h00);
		lvl(udcs_pkg::CMD_RESUME, 20'h4);
		rd_chk("ctl", 3'h2, 8'hc0);
		lvl(udcs_pkg::CMD_SOF, 20'h0);
		rd_chk("evt", 3'h0, 8'h03);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#800000;
		err_count++;
		$display("wrong value run exp done got hang");
		wrap_up();
	end
	initial begin
		{rst, reg_wr, reg_rd, global_irq_dis, cmd_valid, cmd_dir} = 6'h20;
		{reg_addr, reg_wdata, cmd_len, cmd_pid, cmd_ep, cmd_addr, cmd_fault} = '0;
		cmd_kind = udcs_pkg::CMD_RESET;
		err_count = 0;
		checked = 0;
		repeat (12) @(posedge mclk);
		rst <= 1'h0;
		wait_ready();
		t_reset_wake();
		t_regs();
		t_bus_reset();
		t_setup();
		t_fault();
		t_idle();
		t_force_reset();
		wrap_up();
	end
endmodule // tb_usb_device_control_status

`default_nettype wire
